// ===== inc/acs_pkg.sv
// Constants, types and register map of the converter sleep/result block.
// Assumes an APB master at 40 MHz and an analog core reached by start/done pins.
// Contract
// - Sleep in idle or low-noise mode with converter ready starts a conversion.
// - Undisturbed sleep conversion wakes the processor through its done interrupt.
// - Earlier wake lets conversion finish and still raise its done request.
// - Other sleep modes leave the converter enable state untouched.
// - After done flag sets, result stays held in low and high result bytes.
// - Single-ended result is unsigned 10-bit, 0x000 ground to 0x3FF.
// - Differential result is two's complement 0x200 to 0x1FF, saturating.
// - Bit nine of a differential result is the sign bit.
// - Right align: low byte bits 7..0, high byte bits 9..8; left: high 9..2.
// - Left-align bit set gives left adjust, cleared gives right adjust.
// - Changing left-align alters the result bytes at once, even mid-conversion.
`default_nettype none
package acs_pkg;
  localparam logic [11:0] ACS_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ACS_ADDR_STATUS = 12'h004;
  localparam logic [11:0] ACS_ADDR_MASK   = 12'h008;
  localparam logic [11:0] ACS_ADDR_LOW    = 12'h00C;
  localparam logic [11:0] ACS_ADDR_HIGH   = 12'h010;
  localparam logic [11:0] ACS_ADDR_SLEEP  = 12'h014;
  // Control bit positions
  localparam int ACS_CTRL_EN    = 0;
  localparam int ACS_CTRL_START = 1;
  localparam int ACS_CTRL_IE    = 2;
  localparam int ACS_CTRL_LEFT  = 3;
  localparam int ACS_CTRL_DIFF  = 4;
  localparam int ACS_CTRL_SINGLE = 5;
  // Status bits: done flag, woke-by-converter flag
  localparam int ACS_ST_DONE = 0;
  localparam int ACS_ST_WAKE = 1;
  localparam int ACS_ST_W    = 2;
  localparam logic [9:0] ACS_DIFF_MIN = 10'h200;
  localparam logic [9:0] ACS_DIFF_MAX = 10'h1FF;
  localparam logic [9:0] ACS_SE_MAX   = 10'h3FF;
  localparam int ACS_SIGN_BIT = 9;
  // Sleep mode codes written by the power controller
  typedef enum logic [2:0] {
    ACS_SLP_IDLE  = 3'h0,
    ACS_SLP_NOISE = 3'h1,
    ACS_SLP_DOWN  = 3'h2,
    ACS_SLP_SAVE  = 3'h3,
    ACS_SLP_STBY  = 3'h6,
    ACS_SLP_XSTBY = 3'h7
  } acs_sleep_e;
  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_CONV  = 2'b01,
    ACS_HOLD  = 2'b11
  } acs_state_e;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acs_apb_rsp_s;
  typedef struct packed {
    acs_state_e          state;
    logic                enable;
    logic                irq_en;
    logic                left_align;
    logic                diff_mode;
    logic                single_mode;
    logic                asleep;
    logic                sleep_conv;
    logic [9:0]          result;
    logic [ACS_ST_W-1:0] status;
    logic [ACS_ST_W-1:0] mask;
    logic                conv_start;
    logic                wake;
    logic                irq;
    logic [7:0]          low_byte;
    logic [7:0]          high_byte;
    acs_apb_rsp_s        rsp;
  } acs_state_s;
endpackage
`default_nettype wire

// ===== logic/acs_ctrl.sv
// Converter control: sleep-time start, done flag, result coding and alignment.
// Assumes a synchronous analog core answering conv_start with one done pulse and a raw code.
`default_nettype none
module acs_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sleep_req,
  input  wire logic [2:0]  sleep_mode,
  input  wire logic        core_halted,
  input  wire logic        other_wake,
  input  wire logic        analog_done,
  input  wire logic [10:0] analog_raw,
  output var  logic        conv_start,
  output var  logic        converter_enable,
  output var  logic        cpu_wake,
  output var  logic        irq,
  output var  logic [7:0]  result_low_byte,
  output var  logic [7:0]  result_high_byte
);
  acs_pkg::acs_state_s r;
  acs_pkg::acs_state_s next_r;

  logic       setup;
  logic       access;
  logic       quiet_sleep;
  logic [9:0] coded;
  logic [9:0] shown;
  localparam int ACS_ST_W_LOCAL = acs_pkg::ACS_ST_W;
  logic [ACS_ST_W_LOCAL-1:0] ev;

  // Raw code is 11-bit signed for differential so over-range can be clipped
  always_comb begin
    if (r.diff_mode) begin
      if ($signed(analog_raw) > $signed({1'b0, acs_pkg::ACS_DIFF_MAX})) begin
        coded = acs_pkg::ACS_DIFF_MAX;
      end else if ($signed(analog_raw) < $signed({1'b1, acs_pkg::ACS_DIFF_MIN})) begin
        coded = acs_pkg::ACS_DIFF_MIN;
      end else begin
        coded = analog_raw[9:0];
      end
    end else begin
      coded = analog_raw[10] ? 10'h000 :
              (analog_raw[10:0] > {1'b0, acs_pkg::ACS_SE_MAX}) ? acs_pkg::ACS_SE_MAX :
              analog_raw[9:0];
    end
  end

  assign setup       = psel && !penable;
  assign access      = psel && penable;
  assign quiet_sleep = sleep_mode == acs_pkg::ACS_SLP_IDLE ||
                       sleep_mode == acs_pkg::ACS_SLP_NOISE;
  assign shown       = r.result;

  always_comb begin
    next_r = r;
    next_r.conv_start = 1'b0;
    next_r.rsp.pready = 1'b0;
    ev = '0;

    // Wake state follows the sleep request; an outside wake ends it too
    if (sleep_req && core_halted) begin
      next_r.asleep = 1'b1;
    end
    // Dropping the sleep command also ends sleep, so a later entry can start again
    if (other_wake || r.wake || !sleep_req) begin
      next_r.asleep = 1'b0;
    end

    case (r.state)
      acs_pkg::ACS_IDLE: begin
        if (r.enable && sleep_req && core_halted && !r.asleep && quiet_sleep) begin
          next_r.conv_start = 1'b1;
          next_r.sleep_conv = 1'b1;
          next_r.state      = acs_pkg::ACS_CONV;
        end
      end
      acs_pkg::ACS_CONV: begin
        if (!r.enable) begin
          next_r.state      = acs_pkg::ACS_IDLE;
          next_r.sleep_conv = 1'b0;
        end else if (analog_done) begin
          // Completion runs regardless of an earlier wake
          next_r.result = coded;
          ev[acs_pkg::ACS_ST_DONE] = 1'b1;
          ev[acs_pkg::ACS_ST_WAKE] = r.sleep_conv && r.asleep && r.irq_en;
          next_r.state      = acs_pkg::ACS_HOLD;
          next_r.sleep_conv = 1'b0;
        end
      end
      acs_pkg::ACS_HOLD: begin
        // A software start or a new sleep entry restarts; sleep entry waits for sleep_req to drop first
        if (!sleep_req) begin
          next_r.state = acs_pkg::ACS_IDLE;
        end
      end
      default: next_r.state = acs_pkg::ACS_IDLE;
    endcase

    // Converter wakes processor when its done interrupt is enabled and a sleep-started conversion ends while still asleep
    next_r.wake = ev[acs_pkg::ACS_ST_WAKE];

    if (access && !r.rsp.pready) begin
      next_r.rsp.pready  = 1'b1;
      next_r.rsp.pslverr = 1'b0;
      next_r.rsp.prdata  = '0;
      case (paddr)
        acs_pkg::ACS_ADDR_CTRL: begin
          if (pwrite) begin
            // Deep sleep never touches this bit; only software does
            next_r.enable      = pwdata[acs_pkg::ACS_CTRL_EN];
            next_r.irq_en      = pwdata[acs_pkg::ACS_CTRL_IE];
            next_r.left_align  = pwdata[acs_pkg::ACS_CTRL_LEFT];
            next_r.diff_mode   = pwdata[acs_pkg::ACS_CTRL_DIFF];
            next_r.single_mode = pwdata[acs_pkg::ACS_CTRL_SINGLE];
            if (pwdata[acs_pkg::ACS_CTRL_START] && pwdata[acs_pkg::ACS_CTRL_EN] &&
                r.state != acs_pkg::ACS_CONV) begin
              next_r.conv_start = 1'b1;
              next_r.sleep_conv = 1'b0;
              next_r.state      = acs_pkg::ACS_CONV;
            end
          end else begin
            next_r.rsp.prdata[acs_pkg::ACS_CTRL_EN]     = r.enable;
            next_r.rsp.prdata[acs_pkg::ACS_CTRL_START]  = r.state == acs_pkg::ACS_CONV;
            next_r.rsp.prdata[acs_pkg::ACS_CTRL_IE]     = r.irq_en;
            next_r.rsp.prdata[acs_pkg::ACS_CTRL_LEFT]   = r.left_align;
            next_r.rsp.prdata[acs_pkg::ACS_CTRL_DIFF]   = r.diff_mode;
            next_r.rsp.prdata[acs_pkg::ACS_CTRL_SINGLE] = r.single_mode;
          end
        end
        acs_pkg::ACS_ADDR_STATUS: begin
          if (pwrite) begin
            next_r.status = r.status & ~pwdata[ACS_ST_W_LOCAL-1:0];
          end else begin
            next_r.rsp.prdata[ACS_ST_W_LOCAL-1:0] = r.status;
          end
        end
        acs_pkg::ACS_ADDR_MASK: begin
          if (pwrite) begin
            next_r.mask = pwdata[ACS_ST_W_LOCAL-1:0];
          end else begin
            next_r.rsp.prdata[ACS_ST_W_LOCAL-1:0] = r.mask;
          end
        end
        acs_pkg::ACS_ADDR_LOW: begin
          if (!pwrite) begin
            next_r.rsp.prdata[7:0] = r.low_byte;
          end
        end
        acs_pkg::ACS_ADDR_HIGH: begin
          if (!pwrite) begin
            next_r.rsp.prdata[7:0] = r.high_byte;
          end
        end
        acs_pkg::ACS_ADDR_SLEEP: begin
          if (!pwrite) begin
            next_r.rsp.prdata[0] = r.asleep;
            next_r.rsp.prdata[1] = r.sleep_conv;
          end
        end
        default: next_r.rsp.pslverr = 1'b1;
      endcase
    end

    // Set beats a same-cycle clear
    next_r.status = next_r.status | ev;

    // Bytes follow alignment at once, using the next align value
    if (next_r.left_align) begin
      next_r.high_byte = next_r.result[9:2];
      next_r.low_byte  = {next_r.result[1:0], 6'h00};
    end else begin
      next_r.high_byte = {6'h00, next_r.result[9:8]};
      next_r.low_byte  = next_r.result[7:0];
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign prdata           = r.rsp.prdata;
  assign pready           = r.rsp.pready;
  assign pslverr          = r.rsp.pslverr;
  assign conv_start       = r.conv_start;
  assign converter_enable = r.enable;
  assign cpu_wake         = r.wake;
  assign irq              = r.irq;
  assign result_low_byte  = r.low_byte;
  assign result_high_byte = r.high_byte;
endmodule
`default_nettype wire

// ===== test/acs_ctrl_properties.sv
// Port-level checker for the converter control block.
// Assumes it is bound to every acs_ctrl instance.
`default_nettype none
module acs_ctrl_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       sleep_req,
  input wire logic [2:0] sleep_mode,
  input wire logic       core_halted,
  input wire logic       analog_done,
  input wire logic       conv_start,
  input wire logic       converter_enable,
  input wire logic       cpu_wake,
  input wire logic [7:0] result_low_byte,
  input wire logic [7:0] result_high_byte
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus kept quiet so a register write cannot be the cause
  sequence s_enter;
    $rose(sleep_req && core_halted) && converter_enable && !psel &&
      (sleep_mode inside {acs_pkg::ACS_SLP_IDLE, acs_pkg::ACS_SLP_NOISE});
  endsequence
  sequence s_deep;
    sleep_req && core_halted && !psel &&
      !(sleep_mode inside {acs_pkg::ACS_SLP_IDLE, acs_pkg::ACS_SLP_NOISE});
  endsequence
  sequence s_quiet;
    !analog_done && !$past(analog_done) && !psel && !$past(psel);
  endsequence
  AST_SLEEP_START: assert property (s_enter |=> conv_start)
    else $error("sleep entry gave no start");
  AST_DEEP_NO_START: assert property (s_deep |=> !conv_start)
    else $error("deep sleep started a conversion");
  AST_DEEP_ENABLE: assert property (s_deep |=> $stable(converter_enable))
    else $error("deep sleep changed enable");
  AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  AST_WAKE_CAUSE: assert property (cpu_wake |-> $past(analog_done) ##1 !cpu_wake)
    else $error("wake without completion");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable) ##1 !pready)
    else $error("ready without access");
  AST_LAYOUT: assert property (result_high_byte[7:2] == 6'h00 || result_low_byte[5:0] == 6'h00)
    else $error("result bytes fit no alignment");
  AST_RESULT_HOLD: assert property (s_quiet |=>
      $stable(result_low_byte) && $stable(result_high_byte))
    else $error("result changed with no cause");
endmodule
bind acs_ctrl acs_ctrl_properties u_acs_ctrl_properties (.pclk, .presetn, .psel, .penable,
  .pready, .sleep_req, .sleep_mode, .core_halted, .analog_done, .conv_start,
  .converter_enable, .cpu_wake, .result_low_byte, .result_high_byte);
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the converter control block.
// Assumes APB answers with a wait state and all outputs are registered.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req;
  logic        core_halted, other_wake, analog_done, conv_start, converter_enable;
  logic        cpu_wake, irq, er, l, d;
  logic [2:0]  sleep_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] analog_raw, r;
  logic [7:0]  result_low_byte, result_high_byte;
  logic [15:0] ex;
  logic [10:0] bnd [6] = '{11'h400, 11'h7FF, 11'h000, 11'h1FF, 11'h200, 11'h3FF};
  int          err_total, compares, seed, starts, wakes, n, w;
  acs_ctrl u_acs_ctrl (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_req, .sleep_mode, .core_halted,
    .other_wake, .analog_done, .analog_raw, .conv_start, .converter_enable, .cpu_wake,
    .irq, .result_low_byte, .result_high_byte);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (conv_start === 1'b1) starts++;
    if (cpu_wake === 1'b1) wakes++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Behavioural result: saturate, then place in the two bytes
  function automatic logic [15:0] model(input logic [10:0] x, input logic df, input logic lf);
    int v;
    logic [9:0] c;
    v = $signed(x);
    if (df) v = (v > 511) ? 511 : ((v < -512) ? -512 : v);
    else v = (v < 0) ? 0 : v;
    c = v[9:0];
    return lf ? {c[9:2], c[1:0], 6'h00} : {6'h00, c[9:8], c[7:0]};
  endfunction
  // Raw value is scrambled once the done pulse is over
  task automatic conv(input logic [10:0] x);
    @(posedge pclk);
    analog_done <= 1'b1;
    analog_raw <= x;
    @(posedge pclk);
    analog_done <= 1'b0;
    analog_raw <= ~x;
    repeat (2) @(posedge pclk);
  endtask
  task automatic complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    err_total++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, core_halted, other_wake, analog_done} = 8'h00;
    {sleep_mode, paddr, pwdata, analog_raw} = 58'h0;
    seed = 32'h3CAC;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, acs_pkg::ACS_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, er);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      r = (i < 12) ? bnd[i % 6] : 11'($random(seed));
      d = (i < 12) ? (i >= 6) : i[1];
      l = i[0];
      apb(1'b1, acs_pkg::ACS_ADDR_CTRL, {26'h0, 1'b1, d, l, 3'h7});
      conv(r);
      ex = model(r, d, l);
      chk("bytes", ex, {result_high_byte, result_low_byte});
      apb(1'b1, acs_pkg::ACS_ADDR_CTRL, {26'h0, 1'b1, d, ~l, 3'h5});
      @(posedge pclk);
      #1;
      ex = model(r, d, ~l);
      chk("realigned", ex, {result_high_byte, result_low_byte});
      apb(1'b0, acs_pkg::ACS_ADDR_HIGH, 32'h0);
      chk("high reg", ex[15:8], rd);
    end
    $display("result test done");
    apb(1'b1, acs_pkg::ACS_ADDR_MASK, 32'h1);
    for (int m = 0; m < 8; m++) begin
      if (m == 4 || m == 5) continue;
      apb(1'b1, acs_pkg::ACS_ADDR_CTRL, 32'h25);
      apb(1'b1, acs_pkg::ACS_ADDR_STATUS, 32'h3);
      n = starts;
      w = wakes;
      @(posedge pclk);
      sleep_mode <= 3'(m);
      sleep_req <= 1'b1;
      core_halted <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("sleep start", (m < 2), starts - n);
      chk("enable kept", 32'h1, converter_enable);
      if (m < 2) begin
        conv(11'h155);
        chk("wake", 32'h1, wakes - w);
        chk("irq", 32'h1, irq);
        apb(1'b1, acs_pkg::ACS_ADDR_STATUS, 32'h3);
        chk("irq cleared", 32'h0, irq);
      end
      @(posedge pclk);
      sleep_req <= 1'b0;
      core_halted <= 1'b0;
    end
    $display("sleep test done");
    apb(1'b1, acs_pkg::ACS_ADDR_CTRL, 32'h20);
    n = starts;
    @(posedge pclk);
    sleep_mode <= acs_pkg::ACS_SLP_DOWN;
    {sleep_req, core_halted} <= 2'h3;
    repeat (4) @(posedge pclk);
    {sleep_req, core_halted} <= 2'h0;
    chk("deep enable", 32'h0, converter_enable);
    chk("deep start", 32'h0, starts - n);
    apb(1'b1, acs_pkg::ACS_ADDR_CTRL, 32'h37);
    conv(11'h590);
    ex = model(11'h590, 1'b1, 1'b0);
    chk("re-enabled diff", ex, {result_high_byte, result_low_byte});
    $display("deep sleep test done");
    apb(1'b1, acs_pkg::ACS_ADDR_MASK, 32'h0);
    @(posedge pclk);
    sleep_mode <= acs_pkg::ACS_SLP_NOISE;
    {sleep_req, core_halted} <= 2'h3;
    @(posedge pclk);
    other_wake <= 1'b1;
    @(posedge pclk);
    {other_wake, sleep_req, core_halted} <= 3'h0;
    conv(11'h2AA);
    apb(1'b0, acs_pkg::ACS_ADDR_STATUS, 32'h0);
    chk("done after early wake", 32'h1, rd[0]);
    chk("masked irq", 32'h0, irq);
    apb(1'b1, acs_pkg::ACS_ADDR_MASK, 32'h1);
    @(posedge pclk);
    chk("unmasked irq", 32'h1, irq);
    $display("early wake test done");
    complete_run();
  end
endmodule
`default_nettype wire
